// >>> logic/wdb_pkg.sv
// Package with the register map, codes, state type and tag request carrier of the block writer.
`default_nettype none
package wdb_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_RESULT = 8'h04;
    localparam logic [7:0] OFF_ARG0 = 8'h08;
    localparam logic [7:0] OFF_ARG1 = 8'h0C;
    localparam logic [7:0] OFF_ARG2 = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN = 8'h1C;
    // Command code and result codes.
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h05;
    localparam logic [7:0] RES_NO_ERROR = 8'h00;
    localparam logic [7:0] RES_ERROR = 8'h01;
    localparam logic [7:0] RES_RESET = 8'h00;
    // Argument byte positions.
    localparam int ARG_BYTES = 10;
    localparam int ARG_BLOCK = 0;
    localparam int ARG_COUNT = 1;
    localparam int ARG_OFFSET = 2;
    localparam int ARG_KEYSEL = 3;
    localparam int ARG_KEY = 4;
    localparam int KEY_BYTES = 6;
    // Key selector fields.
    localparam int KSEL_B = 7;
    localparam int KSEL_INLINE = 6;
    localparam int KSEL_IDX_W = 6;
    // Result register and interrupt bit positions.
    localparam int RES_BUSY_BIT = 8;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_W = 2;
    // Tag geometry: bytes per block and sector layout.
    localparam int BLOCK_BYTES = 16;
    localparam logic [7:0] BIG_SECT_BASE = 8'h80;
    localparam logic [5:0] BIG_SECT_FIRST = 6'h20;
    localparam logic [7:0] LAST_BLOCK = 8'hFF;
    // Tag request operations.
    localparam logic TAG_OP_AUTH = 1'b0;
    localparam logic TAG_OP_WRITE = 1'b1;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CHECK, ST_KEY, ST_SKIP, ST_AUTH, ST_AUTH_W, ST_FETCH, ST_WRITE, ST_WRITE_W
    } wdb_state_e;

    typedef struct packed {
        logic op;
        logic [7:0] blk;
        logic key_b;
        logic [47:0] key;
        logic [127:0] data;
    } wdb_tag_req_s;
endpackage : wdb_pkg
`default_nettype wire

// >>> logic/wdb_blk_map.sv
// Tag block classifier: trailer detection and sector number of a block address.
`default_nettype none
module wdb_blk_map
    import wdb_pkg::*;
(
    // Block address in.
    input wire logic [7:0] blk,
    // Classification out.
    output logic trailer,
    output logic [5:0] sector
);
    logic [7:0] big_off;

    // Small sectors hold four blocks, the large ones above the base hold sixteen.
    always_comb
    begin
        big_off = blk - BIG_SECT_BASE;
        if (blk < BIG_SECT_BASE)
        begin
            trailer = (blk[1:0] == 2'h3);
            sector = blk[7:2];
        end
        else
        begin
            trailer = (blk[3:0] == 4'hF);
            sector = BIG_SECT_FIRST + {2'h0, big_off[7:4]};
        end
    end
endmodule : wdb_blk_map
`default_nettype wire

// >>> logic/wdb_top.sv
// Block write command engine with AHB-Lite register slave, key and buffer ports.
//
// How it works
// - Writing code 0x05 to the command register starts the block write.
// - Argument byte 0 holds the first tag block to write.
// - Argument byte 2 is the data buffer start offset of the write data.
// - Low six bits of argument byte 3 index the stored keys, 0 to 39.
// - Bit 7 of the selector picks key B when set, key A when clear.
// - Bit 6 of the selector takes a six byte key from argument byte 4.
// - The inline key has its least significant byte at the lowest offset.
// - The chosen key drives the authenticated exchange that writes the data.
// - The first sector is authenticated first; failure reports error and ends.
// - Sector trailer blocks are skipped; only data blocks are written.
// - Entering a new sector re-authenticates it with the same key.
// - All blocks written gives no-error; any write failure gives error.
//
// Added by the designer: register access over AHB-Lite and the address map.
`default_nettype none
module wdb_top
    import wdb_pkg::*;
#(
    parameter int BUF_BYTES = 256,
    parameter int NUM_KEYS = 40
)
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Shared data buffer read port, one cycle latency.
    output logic buf_rd,
    output logic [7:0] buf_addr,
    input wire logic [7:0] buf_rdata,
    // Key store lookup, combinational answer.
    output logic [5:0] key_idx,
    input wire logic [47:0] key_data,
    // Tag exchange engine.
    output logic tag_req_valid,
    output wdb_tag_req_s tag_req,
    input wire logic tag_done,
    input wire logic tag_fail,
    // Interrupt.
    output logic irq
);
    import wdb_pkg::*;

    localparam logic [12:0] BUF_LIM = 13'(BUF_BYTES);
    localparam logic [6:0] KEY_LIM = 7'(NUM_KEYS);
    localparam logic [4:0] BLK_LAST_BYTE = 5'(BLOCK_BYTES - 1);
    localparam logic [4:0] BLK_BYTES_W = 5'(BLOCK_BYTES);

    wdb_state_e state_r;
    logic [7:0] arg_r [ARG_BYTES];
    logic [7:0] result_r;
    logic [7:0] blk_r, left_r, ptr_r;
    logic [5:0] cur_sec_r;
    logic auth_ok_r;
    logic [47:0] key_r;
    logic [4:0] iss_r, rcv_r;
    logic [127:0] data_r;
    logic rd_vld_r;
    logic ev_ok_r, ev_err_r;
    logic [IRQ_W-1:0] ist_r, ien_r;
    logic wr_pend_r;
    logic [7:0] wa_r;
    logic hready_r, hresp_r, irq_r, tag_req_valid_r, buf_rd_r;
    logic [31:0] hrdata_r;
    logic [7:0] buf_addr_r;
    logic [5:0] key_idx_r;
    wdb_tag_req_s tag_req_r;

    logic acc, busy, cmd_wr, blk_trl;
    logic [5:0] blk_sec;
    logic [12:0] span;
    logic [IRQ_W-1:0] ev_vec;

    assign acc = hsel & htrans[1] & hready;
    assign busy = (state_r != ST_IDLE);
    assign cmd_wr = wr_pend_r && (wa_r == OFF_CMD) && !busy;
    assign span = {5'h0, arg_r[ARG_OFFSET]} + {1'b0, arg_r[ARG_COUNT], 4'h0};
    assign ev_vec = {ev_err_r, ev_ok_r};

    wdb_blk_map u_map (
        .blk(blk_r),
        .trailer(blk_trl),
        .sector(blk_sec)
    );

    // Address phase is captured here; writes complete in the data phase with no wait state.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wa_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
        end
        else
        begin
            wr_pend_r <= acc & hwrite;
            wa_r <= haddr[7:0];
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
            if (acc && !hwrite)
            begin
                case (haddr[7:0])
                    OFF_RESULT: hrdata_r <= {23'h0, busy, result_r};
                    OFF_ARG0: hrdata_r <= {arg_r[3], arg_r[2], arg_r[1], arg_r[0]};
                    OFF_ARG1: hrdata_r <= {arg_r[7], arg_r[6], arg_r[5], arg_r[4]};
                    OFF_ARG2: hrdata_r <= {16'h0000, arg_r[9], arg_r[8]};
                    OFF_IRQ_STAT: hrdata_r <= {30'h0, ist_r};
                    OFF_IRQ_EN: hrdata_r <= {30'h0, ien_r};
                    default: hrdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Arguments are frozen while a command runs so the engine sees stable values.
    for (genvar g = 0; g < ARG_BYTES; g++)
    begin : g_arg
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                arg_r[g] <= 8'h00;
            else if (wr_pend_r && !busy && wa_r == 8'(OFF_ARG0 + 4 * (g / 4)))
                arg_r[g] <= hwdata[8 * (g % 4) +: 8];
        end
    end

    // Interrupt status: a new event wins over a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ist_r <= '0;
            ien_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            if (wr_pend_r && wa_r == OFF_IRQ_CLR)
                ist_r <= (ist_r & ~hwdata[IRQ_W-1:0]) | ev_vec;
            else
                ist_r <= ist_r | ev_vec;
            if (wr_pend_r && wa_r == OFF_IRQ_EN)
                ien_r <= hwdata[IRQ_W-1:0];
            irq_r <= |(ist_r & ien_r);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_vld_r <= 1'b0;
        else
            rd_vld_r <= buf_rd_r;
    end

    // Command sequencer.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= ST_IDLE;
            result_r <= RES_RESET;
            blk_r <= 8'h00;
            left_r <= 8'h00;
            ptr_r <= 8'h00;
            cur_sec_r <= 6'h00;
            auth_ok_r <= 1'b0;
            key_r <= 48'h0;
            key_idx_r <= 6'h00;
            iss_r <= 5'h00;
            rcv_r <= 5'h00;
            data_r <= 128'h0;
            buf_rd_r <= 1'b0;
            buf_addr_r <= 8'h00;
            tag_req_valid_r <= 1'b0;
            tag_req_r <= '0;
            ev_ok_r <= 1'b0;
            ev_err_r <= 1'b0;
        end
        else
        begin
            ev_ok_r <= 1'b0;
            ev_err_r <= 1'b0;
            tag_req_valid_r <= 1'b0;
            buf_rd_r <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (cmd_wr && hwdata[7:0] == CMD_BLOCK_WRITE)
                        state_r <= ST_CHECK;
                    else if (cmd_wr)
                    begin
                        result_r <= RES_ERROR;
                        ev_err_r <= 1'b1;
                    end
                end
                ST_CHECK:
                begin
                    // Refusal happens before any tag traffic, so a bad command has no side effect.
                    if (arg_r[ARG_COUNT] == 8'h00 || span > BUF_LIM ||
                        (!arg_r[ARG_KEYSEL][KSEL_INLINE] &&
                         {1'b0, arg_r[ARG_KEYSEL][KSEL_IDX_W-1:0]} >= KEY_LIM))
                    begin
                        state_r <= ST_IDLE;
                        result_r <= RES_ERROR;
                        ev_err_r <= 1'b1;
                    end
                    else
                    begin
                        blk_r <= arg_r[ARG_BLOCK];
                        left_r <= arg_r[ARG_COUNT];
                        ptr_r <= arg_r[ARG_OFFSET];
                        key_idx_r <= arg_r[ARG_KEYSEL][KSEL_IDX_W-1:0];
                        auth_ok_r <= 1'b0;
                        state_r <= ST_KEY;
                    end
                end
                ST_KEY:
                begin
                    if (arg_r[ARG_KEYSEL][KSEL_INLINE])
                        key_r <= {arg_r[9], arg_r[8], arg_r[7], arg_r[6], arg_r[5], arg_r[4]};
                    else
                        key_r <= key_data;
                    state_r <= ST_SKIP;
                end
                ST_SKIP:
                begin
                    if (blk_trl && blk_r == LAST_BLOCK)
                    begin
                        state_r <= ST_IDLE;
                        result_r <= RES_ERROR;
                        ev_err_r <= 1'b1;
                    end
                    else if (blk_trl)
                        blk_r <= blk_r + 8'h01;
                    else if (!auth_ok_r || blk_sec != cur_sec_r)
                        state_r <= ST_AUTH;
                    else
                    begin
                        iss_r <= 5'h00;
                        rcv_r <= 5'h00;
                        state_r <= ST_FETCH;
                    end
                end
                ST_AUTH:
                begin
                    tag_req_valid_r <= 1'b1;
                    tag_req_r.op <= TAG_OP_AUTH;
                    tag_req_r.blk <= blk_r;
                    tag_req_r.key_b <= arg_r[ARG_KEYSEL][KSEL_B];
                    tag_req_r.key <= key_r;
                    state_r <= ST_AUTH_W;
                end
                ST_AUTH_W:
                begin
                    if (tag_done && tag_fail)
                    begin
                        state_r <= ST_IDLE;
                        result_r <= RES_ERROR;
                        ev_err_r <= 1'b1;
                    end
                    else if (tag_done)
                    begin
                        cur_sec_r <= blk_sec;
                        auth_ok_r <= 1'b1;
                        iss_r <= 5'h00;
                        rcv_r <= 5'h00;
                        state_r <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    if (iss_r != BLK_BYTES_W)
                    begin
                        buf_rd_r <= 1'b1;
                        buf_addr_r <= ptr_r + {3'h0, iss_r};
                        iss_r <= iss_r + 5'h01;
                    end
                    if (rd_vld_r)
                    begin
                        // Byte at the lowest buffer address ends in the low byte of the block.
                        data_r <= {buf_rdata, data_r[127:8]};
                        rcv_r <= rcv_r + 5'h01;
                        if (rcv_r == BLK_LAST_BYTE)
                            state_r <= ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    tag_req_valid_r <= 1'b1;
                    tag_req_r.op <= TAG_OP_WRITE;
                    tag_req_r.blk <= blk_r;
                    tag_req_r.key_b <= arg_r[ARG_KEYSEL][KSEL_B];
                    tag_req_r.key <= key_r;
                    tag_req_r.data <= data_r;
                    state_r <= ST_WRITE_W;
                end
                ST_WRITE_W:
                begin
                    if (tag_done && tag_fail)
                    begin
                        state_r <= ST_IDLE;
                        result_r <= RES_ERROR;
                        ev_err_r <= 1'b1;
                    end
                    else if (tag_done)
                    begin
                        ptr_r <= ptr_r + 8'(BLOCK_BYTES);
                        left_r <= left_r - 8'h01;
                        if (left_r == 8'h01)
                        begin
                            state_r <= ST_IDLE;
                            result_r <= RES_NO_ERROR;
                            ev_ok_r <= 1'b1;
                        end
                        else if (blk_r == LAST_BLOCK)
                        begin
                            state_r <= ST_IDLE;
                            result_r <= RES_ERROR;
                            ev_err_r <= 1'b1;
                        end
                        else
                        begin
                            blk_r <= blk_r + 8'h01;
                            state_r <= ST_SKIP;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign hreadyout = hready_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
    assign buf_rd = buf_rd_r;
    assign buf_addr = buf_addr_r;
    assign key_idx = key_idx_r;
    assign tag_req_valid = tag_req_valid_r;
    assign tag_req = tag_req_r;
    assign irq = irq_r;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    cmd_start_a: assert property (state_r == ST_CHECK && $past(state_r) == ST_IDLE |->
        $past(cmd_wr) && $past(hwdata[7:0]) == CMD_BLOCK_WRITE)
        else $error("command started without the block write code");
    refuse_zero_a: assert property (state_r == ST_CHECK && arg_r[ARG_COUNT] == 8'h00 |=>
        state_r == ST_IDLE && result_r == RES_ERROR && !tag_req_valid_r)
        else $error("zero block count was not refused");
    start_args_a: assert property (state_r == ST_KEY |->
        $past(state_r) == ST_CHECK && blk_r == arg_r[ARG_BLOCK] && ptr_r == arg_r[ARG_OFFSET])
        else $error("start block or buffer offset not taken from the arguments");
    key_index_a: assert property (state_r == ST_KEY |->
        key_idx_r == arg_r[ARG_KEYSEL][KSEL_IDX_W-1:0])
        else $error("key index differs from the selector bits");
    key_type_a: assert property (tag_req_valid_r |->
        tag_req_r.key_b == arg_r[ARG_KEYSEL][KSEL_B] && tag_req_r.key == key_r)
        else $error("request carries wrong key or key type");
    inline_key_a: assert property (state_r == ST_KEY && arg_r[ARG_KEYSEL][KSEL_INLINE] |=>
        key_r == {arg_r[9], arg_r[8], arg_r[7], arg_r[6], arg_r[5], arg_r[4]})
        else $error("inline key not assembled low byte first");
    trailer_skip_a: assert property (state_r == ST_WRITE |-> !blk_trl)
        else $error("write aimed at a sector trailer");
    auth_fail_a: assert property (state_r == ST_AUTH_W && tag_done && tag_fail |=>
        state_r == ST_IDLE && result_r == RES_ERROR ##1 !tag_req_valid_r)
        else $error("authentication failure did not end with error");
    reauth_a: assert property (state_r == ST_SKIP && !blk_trl && blk_sec != cur_sec_r |=>
        state_r == ST_AUTH ##1 tag_req_valid_r && tag_req_r.op == TAG_OP_AUTH)
        else $error("new sector entered without authentication");
    ptr_step_a: assert property (state_r == ST_WRITE_W && tag_done && !tag_fail |=>
        ptr_r == $past(ptr_r) + 8'h10)
        else $error("buffer pointer did not advance by one block");
    done_ok_a: assert property (state_r == ST_WRITE_W && tag_done && !tag_fail &&
        left_r == 8'h01 |=> result_r == RES_NO_ERROR && state_r == ST_IDLE ##1 ist_r[IRQ_DONE_BIT])
        else $error("last block written without no-error result");
endmodule : wdb_top
`default_nettype wire

// >>> tb/wdb_tag_model.sv
// Model of the tag exchange engine, the shared data buffer and the key store of the block writer.
`default_nettype none
module wdb_tag_model
    import wdb_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Scenario controls.
    input wire logic fail_auth,
    input wire logic fail_write,
    input wire logic [3:0] delay,
    // Buffer and key store.
    input wire logic buf_rd,
    input wire logic [7:0] buf_addr,
    output logic [7:0] buf_rdata,
    input wire logic [5:0] key_idx,
    output logic [47:0] key_data,
    // Tag exchange.
    input wire logic tag_req_valid,
    input wire wdb_tag_req_s tag_req,
    output logic tag_done,
    output logic tag_fail
);
    logic pend_r;
    logic [3:0] cnt_r;
    // Each index gives a different key, so a wrong index cannot pass unseen.
    assign key_data = {6{2'b10, key_idx}};
    // Data is good only the cycle after a read; it toggles otherwise so stale bytes are caught.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            buf_rdata <= 8'h00;
        else if (buf_rd)
            buf_rdata <= buf_addr ^ 8'h5A;
        else
            buf_rdata <= ~buf_rdata;
    end
    // One answer per request after the chosen wait; failures only when a scenario asks.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_r <= 1'b0;
            cnt_r <= 4'h0;
            tag_done <= 1'b0;
            tag_fail <= 1'b0;
        end
        else
        begin
            tag_done <= 1'b0;
            tag_fail <= 1'b0;
            if (tag_req_valid)
            begin
                pend_r <= 1'b1;
                cnt_r <= delay;
            end
            else if (pend_r && cnt_r == 4'h0)
            begin
                pend_r <= 1'b0;
                tag_done <= 1'b1;
                tag_fail <= (tag_req.op == TAG_OP_WRITE) ? fail_write : fail_auth;
            end
            else if (pend_r)
                cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule : wdb_tag_model
`default_nettype wire

// >>> tb/wdb_top_tb_top.sv
// Self-checking bench of the block writer: command rows, refusals, interrupts and bus decode.
`default_nettype none
module wdb_top_tb_top
    import wdb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] blk, cnt, off, ksel;
        logic [47:0] key;
        logic fa, fw;
        logic [7:0] res, na, nw, lastb;
    } wdb_row_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, buf_rd, tag_req_valid, tag_done, tag_fail, irq;
    logic [31:0] hrdata, rd;
    logic [7:0] buf_addr, buf_rdata, first_auth, last_write, exp_off;
    logic [5:0] key_idx;
    logic [47:0] key_data, exp_key;
    logic [127:0] exp_data;
    logic exp_kb;
    logic fail_auth = 1'b0;
    logic fail_write = 1'b0;
    logic [3:0] delay = 4'h0;
    wdb_tag_req_s tag_req;
    int fails = 0;
    int samples_checked = 0;
    int n_auth = 0;
    int n_write = 0;
    // The row counter lets the request monitor alone own the per-row tallies.
    int row_id = 0;
    int seen_row = 0;
    // Slow answers sit beside prompt ones; key bytes in row 0 are junk that must be ignored.
    wdb_row_s rows [11] = '{
        '{8'h04, 8'h01, 8'h00, 8'h03, 48'hFFEEDDCCBBAA, 1'b0, 1'b0, 8'h00, 8'h01, 8'h01, 8'h04},
        '{8'h01, 8'h03, 8'h10, 8'h85, 48'h0, 1'b0, 1'b0, 8'h00, 8'h02, 8'h03, 8'h04},
        '{8'h08, 8'h01, 8'h20, 8'hC0, 48'h665544332211, 1'b0, 1'b0, 8'h00, 8'h01, 8'h01, 8'h08},
        '{8'h04, 8'h00, 8'h00, 8'h03, 48'h0, 1'b0, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00},
        '{8'h04, 8'h02, 8'hF0, 8'h03, 48'h0, 1'b0, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00},
        '{8'h04, 8'h01, 8'h00, 8'h28, 48'h0, 1'b0, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00},
        '{8'h04, 8'h01, 8'h00, 8'h03, 48'h0, 1'b1, 1'b0, 8'h01, 8'h01, 8'h00, 8'h00},
        '{8'h04, 8'h02, 8'h00, 8'h03, 48'h0, 1'b0, 1'b1, 8'h01, 8'h01, 8'h01, 8'h04},
        '{8'h8E, 8'h02, 8'h00, 8'h07, 48'h0, 1'b0, 1'b0, 8'h00, 8'h02, 8'h02, 8'h90},
        '{8'hFE, 8'h02, 8'h00, 8'h07, 48'h0, 1'b0, 1'b0, 8'h01, 8'h01, 8'h01, 8'hFE},
        '{8'h0C, 8'h02, 8'hE0, 8'h27, 48'h0, 1'b0, 1'b0, 8'h00, 8'h01, 8'h02, 8'h0D}
    };
    assign hready = hreadyout;
    always #50 hclk = ~hclk;
    wdb_top wdb_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .buf_rd(buf_rd),
        .buf_addr(buf_addr), .buf_rdata(buf_rdata), .key_idx(key_idx), .key_data(key_data),
        .tag_req_valid(tag_req_valid), .tag_req(tag_req), .tag_done(tag_done),
        .tag_fail(tag_fail), .irq(irq));
    wdb_tag_model wdb_tag_model_i (.hclk(hclk), .hresetn(hresetn), .fail_auth(fail_auth),
        .fail_write(fail_write), .delay(delay), .buf_rd(buf_rd), .buf_addr(buf_addr),
        .buf_rdata(buf_rdata), .key_idx(key_idx), .key_data(key_data),
        .tag_req_valid(tag_req_valid), .tag_req(tag_req), .tag_done(tag_done),
        .tag_fail(tag_fail));
    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // One single word transfer; the slave may stretch either phase, so every wait is bounded.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        check("address ready", hready, 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 100)
        begin
            @(posedge hclk);
            n++;
        end
        check("data ready", hready, 1'b1);
        rd = hrdata;
        check("bus response", hresp, 1'b0);
    endtask : bus
    task automatic run_row(input wdb_row_s r);
        int n;
        n = 0;
        fail_auth <= r.fa;
        fail_write <= r.fw;
        exp_key = r.ksel[KSEL_INLINE] ? r.key : {6{2'b10, r.ksel[5:0]}};
        exp_kb = r.ksel[KSEL_B];
        exp_off = r.off;
        row_id++;
        bus(1'b1, OFF_ARG0, {r.ksel, r.off, r.cnt, r.blk});
        bus(1'b1, OFF_ARG1, r.key[31:0]);
        bus(1'b1, OFF_ARG2, {16'h0000, r.key[47:32]});
        bus(1'b1, OFF_CMD, {24'h000000, CMD_BLOCK_WRITE});
        repeat (2) @(posedge hclk);
        rd = 32'h00000100;
        while (rd[RES_BUSY_BIT] !== 1'b0 && n < 400)
        begin
            bus(1'b0, OFF_RESULT, 32'h0);
            n++;
        end
        check("busy cleared", rd[RES_BUSY_BIT], 1'b0);
        check("result", rd[7:0], r.res);
        check("auth count", n_auth, r.na);
        check("write count", n_write, r.nw);
        check("last block", last_write, r.lastb);
        if (r.na != 8'h00)
            check("first auth block", first_auth, r.blk);
    endtask : run_row
    // Every request carries the chosen key; writes carry the next block of the buffer.
    always @(posedge hclk)
    begin
        if (seen_row != row_id)
        begin
            seen_row = row_id;
            n_auth = 0;
            n_write = 0;
            last_write = 8'h00;
        end
        if (tag_req_valid === 1'b1)
        begin
            check("request key", tag_req.key, exp_key);
            check("request key side", tag_req.key_b, exp_kb);
            if (tag_req.op === TAG_OP_AUTH)
            begin
                if (n_auth == 0)
                    first_auth = tag_req.blk;
                n_auth++;
            end
            else
            begin
                for (int i = 0; i < BLOCK_BYTES; i++)
                    exp_data[8*i +: 8] = (exp_off + 8'(BLOCK_BYTES * n_write) + 8'(i)) ^ 8'h5A;
                check("write data", tag_req.data, exp_data);
                last_write = tag_req.blk;
                n_write++;
            end
        end
    end
    initial
    begin
        #5_000_000;
        fails++;
        wrap_up();
    end
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("irq at reset", irq, 1'b0);
        check("request at reset", tag_req_valid, 1'b0);
        bus(1'b0, OFF_RESULT, 32'h0);
        check("result at reset", rd[7:0], RES_RESET);
        foreach (rows[i])
        begin
            delay <= 4'((i * 5) % 16);
            run_row(rows[i]);
        end
        bus(1'b0, OFF_IRQ_STAT, 32'h0);
        check("status sticky", rd[1:0], 2'b11);
        check("irq masked", irq, 1'b0);
        bus(1'b1, OFF_IRQ_EN, 32'h00000002);
        repeat (2) @(posedge hclk);
        check("irq enabled", irq, 1'b1);
        bus(1'b1, OFF_IRQ_CLR, 32'h00000003);
        bus(1'b0, OFF_IRQ_STAT, 32'h0);
        check("status cleared", rd[1:0], 2'b00);
        check("irq cleared", irq, 1'b0);
        run_row(rows[0]);
        check("irq other bit", irq, 1'b0);
        bus(1'b1, OFF_IRQ_EN, 32'h00000001);
        repeat (2) @(posedge hclk);
        check("irq done", irq, 1'b1);
        bus(1'b1, OFF_CMD, 32'h00000006);
        repeat (2) @(posedge hclk);
        bus(1'b0, OFF_RESULT, 32'h0);
        check("other code", rd[7:0], RES_ERROR);
        bus(1'b1, 8'h40, 32'hA5A5A5A5);
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped read", rd, 32'h00000000);
        wrap_up();
    end
endmodule : wdb_top_tb_top
`default_nettype wire
